// ===== include/pmrc_map.vh
// Register offsets, field positions, reset values and timing counts of the power mode and reset control block
`ifndef PMRC_MAP_VH
`define PMRC_MAP_VH
// Byte offsets on the register bus
`define PMRC_OFF_CLKSEL 12'h000
`define PMRC_OFF_CAUSE 12'h004
`define PMRC_OFF_CFG 12'h008
`define PMRC_OFF_MODE 12'h00c
`define PMRC_OFF_IRQ_STAT 12'h010
`define PMRC_OFF_IRQ_EN 12'h014
`define PMRC_OFF_IRQ_CLR 12'h018
`define PMRC_OFF_CTRL 12'h01c
// Field positions
`define PMRC_GATE_BIT 7
`define PMRC_SRC_HI 1
`define PMRC_SRC_LO 0
`define PMRC_PIN_EN_BIT 7
`define PMRC_SUBSEL_HI 5
`define PMRC_SUBSEL_LO 4
`define PMRC_CTRL_SWRST_BIT 0
`define PMRC_CTRL_REARM_BIT 1
// Reset-cause flag bits, active low as software expects
`define PMRC_RI_BIT 4
`define PMRC_TO_BIT 3
`define PMRC_PD_BIT 2
`define PMRC_POR_BIT 1
`define PMRC_BOR_BIT 0
// Reset values
`define PMRC_CLKSEL_RST 8'h00
`define PMRC_CFG_RST 8'h80
`define PMRC_CAUSE_RST 5'h1c
// Power mode codes
`define PMRC_M_PRIMARY_RUN 3'h0
`define PMRC_M_SECONDARY_RUN 3'h1
`define PMRC_M_INT_RUN 3'h2
`define PMRC_M_PRIMARY_IDLE 3'h3
`define PMRC_M_SECONDARY_IDLE 3'h4
`define PMRC_M_INT_IDLE 3'h5
`define PMRC_M_SLEEP 3'h6
// Reset kinds
`define PMRC_K_NONE 3'h0
`define PMRC_K_PIN_RUN 3'h1
`define PMRC_K_PIN_SLEEP 3'h2
`define PMRC_K_WDT 3'h3
`define PMRC_K_BOR 3'h4
`define PMRC_K_INSTR 3'h5
`define PMRC_K_STK_FULL 3'h6
`define PMRC_K_STK_UNDER 3'h7
// Pin glitch filter: 20 clocks of 10 ns before a low pin counts
`define PMRC_FILT_CYC 8'h14
// Clock switch handshake: cycles the old gate is held off before the new one opens
`define PMRC_SWITCH_CYC 4'h3
`endif

// ===== rtl/pmrc_top.v
// Power mode sequencing, clock gating and reset cause control with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "pmrc_map.vh"
//======================================================================
module pmrc_top (
	input wire core_clk,
	input wire rst_n,
	input wire por_n,
	input wire external_reset_pin_n,
	input wire brownout_evt,
	input wire sleep_instr,
	input wire reset_instr,
	input wire stack_full,
	input wire stack_under,
	input wire irq_wake,
	input wire watchdog_timeout,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg cpu_clk_en,
	output reg periph_clk_en,
	output reg pri_osc_sel,
	output reg sec_osc_sel,
	output reg int_fast_sel,
	output reg int_post_sel,
	output reg int_slow_sel,
	output reg sys_reset_req,
	output reg irq
);
	//======================================================================
	// Input synchronisers
	reg [1:0] pin_s_r, por_s_r, bor_s_r, wdt_s_r;
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s_r <= 2'h3;
			por_s_r <= 2'h0;
			bor_s_r <= 2'h0;
			wdt_s_r <= 2'h0;
		end
		else
		begin
			pin_s_r <= {pin_s_r[0], external_reset_pin_n};
			por_s_r <= {por_s_r[0], por_n};
			bor_s_r <= {bor_s_r[0], brownout_evt};
			wdt_s_r <= {wdt_s_r[0], watchdog_timeout};
		end
	end
	wire pin_low = ~pin_s_r[1];
	wire por_act = ~por_s_r[1];
	wire bor_act = bor_s_r[1];
	wire wdt_act = wdt_s_r[1];

	//======================================================================
	// Registers held by software
	reg [7:0] clock_select_reg_r, config_byte_high3_r;
	reg [4:0] reset_cause_reg_r;
	reg [7:0] irq_stat_r, irq_en_r;
	reg [2:0] mode_r;
	reg swrst_r;
	wire cpu_gate_select = clock_select_reg_r[`PMRC_GATE_BIT];
	wire [1:0] clock_source_select = clock_select_reg_r[`PMRC_SRC_HI:`PMRC_SRC_LO];
	wire external_reset_pin_enable = config_byte_high3_r[`PMRC_PIN_EN_BIT];

	//======================================================================
	// External reset pin filter
	// The pin is only sampled, never driven, so no output enable exists
	reg [7:0] filt_cnt_r;
	reg pin_rst_r;
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			filt_cnt_r <= 8'h00;
			pin_rst_r <= 1'b0;
		end
		else if (!pin_low || !external_reset_pin_enable)
		begin
			filt_cnt_r <= 8'h00;
			pin_rst_r <= 1'b0;
		end
		else if (filt_cnt_r < `PMRC_FILT_CYC) // Short pulses never reach the count
			filt_cnt_r <= filt_cnt_r + 8'h01;
		else
			pin_rst_r <= 1'b1;
	end

	//======================================================================
	// Reset kind and cause flags
	function [2:0] pmrc_mode_of;
		input gate;
		input [1:0] src;
		begin
			if (src[1])
				pmrc_mode_of = gate ? `PMRC_M_INT_IDLE : `PMRC_M_INT_RUN;
			else if (src[0])
				pmrc_mode_of = gate ? `PMRC_M_SECONDARY_IDLE : `PMRC_M_SECONDARY_RUN;
			else
				pmrc_mode_of = gate ? `PMRC_M_PRIMARY_IDLE : `PMRC_M_SLEEP;
		end
	endfunction

	wire in_low_power = (mode_r != `PMRC_M_PRIMARY_RUN);
	reg [2:0] kind;
	always @*
	begin
		kind = `PMRC_K_NONE;
		if (pin_rst_r)
			kind = (mode_r == `PMRC_M_SLEEP) ? `PMRC_K_PIN_SLEEP : `PMRC_K_PIN_RUN;
		else if (bor_act)
			kind = `PMRC_K_BOR;
		else if (wdt_act && !in_low_power)
			kind = `PMRC_K_WDT;
		else if (reset_instr || swrst_r)
			kind = `PMRC_K_INSTR;
		else if (stack_full)
			kind = `PMRC_K_STK_FULL;
		else if (stack_under)
			kind = `PMRC_K_STK_UNDER;
	end
	wire any_reset = por_act || (kind != `PMRC_K_NONE);
	wire wdt_wake = wdt_act && in_low_power; // Resume, not reset
	reg wdt_d_r;
	wire wdt_edge = wdt_act && !wdt_d_r;

	//======================================================================
	// Mode sequencer
	reg [3:0] sw_cnt_r;
	reg [2:0] tgt_r;
	wire [2:0] req_mode = pmrc_mode_of(cpu_gate_select, clock_source_select);
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_r <= `PMRC_M_PRIMARY_RUN;
			tgt_r <= `PMRC_M_PRIMARY_RUN;
			sw_cnt_r <= 4'h0;
			wdt_d_r <= 1'b0;
		end
		else
		begin
			wdt_d_r <= wdt_act;
			if (sw_cnt_r <= 4'h1)
				mode_r <= tgt_r; // Lands with the last held-off cycle so the old mode never reopens
			if (any_reset || irq_wake || wdt_wake)
			begin
				tgt_r <= `PMRC_M_PRIMARY_RUN;
				if (tgt_r != `PMRC_M_PRIMARY_RUN)
					sw_cnt_r <= `PMRC_SWITCH_CYC;
				else if (sw_cnt_r != 4'h0)
					sw_cnt_r <= sw_cnt_r - 4'h1;
			end
			else if (sleep_instr && (mode_r == tgt_r))
			begin
				tgt_r <= req_mode; // Reduced run may go to any mode but primary run, sleep and matching idle included
				sw_cnt_r <= `PMRC_SWITCH_CYC;
			end
			else if (sw_cnt_r != 4'h0)
				sw_cnt_r <= sw_cnt_r - 4'h1; // All gates held off while switching
		end
	end

	//======================================================================
	// Clock gating and source outputs
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_clk_en <= 1'b1;
			periph_clk_en <= 1'b1;
			pri_osc_sel <= 1'b1;
			sec_osc_sel <= 1'b0;
			int_fast_sel <= 1'b0;
			int_post_sel <= 1'b0;
			int_slow_sel <= 1'b0;
		end
		else if (sw_cnt_r != 4'h0)
		begin
			cpu_clk_en <= 1'b0; // Break before make
			periph_clk_en <= 1'b0;
			pri_osc_sel <= 1'b0;
			sec_osc_sel <= 1'b0;
			int_fast_sel <= 1'b0;
			int_post_sel <= 1'b0;
			int_slow_sel <= 1'b0;
		end
		else
		begin
			cpu_clk_en <= (mode_r <= `PMRC_M_INT_RUN);
			periph_clk_en <= (mode_r != `PMRC_M_SLEEP);
			pri_osc_sel <= (mode_r == `PMRC_M_PRIMARY_RUN) || (mode_r == `PMRC_M_PRIMARY_IDLE);
			sec_osc_sel <= (mode_r == `PMRC_M_SECONDARY_RUN) || (mode_r == `PMRC_M_SECONDARY_IDLE);
			int_fast_sel <= ((mode_r == `PMRC_M_INT_RUN) || (mode_r == `PMRC_M_INT_IDLE))
				&& (config_byte_high3_r[`PMRC_SUBSEL_HI:`PMRC_SUBSEL_LO] == 2'h0);
			int_post_sel <= ((mode_r == `PMRC_M_INT_RUN) || (mode_r == `PMRC_M_INT_IDLE))
				&& (config_byte_high3_r[`PMRC_SUBSEL_HI:`PMRC_SUBSEL_LO] == 2'h1);
			int_slow_sel <= ((mode_r == `PMRC_M_INT_RUN) || (mode_r == `PMRC_M_INT_IDLE))
				&& config_byte_high3_r[`PMRC_SUBSEL_HI];
		end
	end

	//======================================================================
	// AXI4-Lite slave
	reg [11:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg aw_got_r, w_got_r;
	wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
	wire wr_clk = wr_go && (awaddr_r == `PMRC_OFF_CLKSEL) && wstrb_r[0];
	wire wr_cfg = wr_go && (awaddr_r == `PMRC_OFF_CFG) && wstrb_r[0];
	wire wr_en = wr_go && (awaddr_r == `PMRC_OFF_IRQ_EN) && wstrb_r[0];
	wire wr_clr = wr_go && (awaddr_r == `PMRC_OFF_IRQ_CLR) && wstrb_r[0];
	wire wr_ctl = wr_go && (awaddr_r == `PMRC_OFF_CTRL) && wstrb_r[0];
	wire wr_map = (awaddr_r == `PMRC_OFF_CLKSEL) || (awaddr_r == `PMRC_OFF_CFG) || (awaddr_r == `PMRC_OFF_IRQ_EN)
		|| (awaddr_r == `PMRC_OFF_IRQ_CLR) || (awaddr_r == `PMRC_OFF_CTRL);
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
		end
		else
		begin
			s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_r <= 1'b1;
				awaddr_r <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? 2'h0 : 2'h2;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case ({s_axi_araddr[11:2], 2'h0})
					`PMRC_OFF_CLKSEL: s_axi_rdata <= {24'h0, clock_select_reg_r};
					`PMRC_OFF_CAUSE: s_axi_rdata <= {27'h0, reset_cause_reg_r};
					`PMRC_OFF_CFG: s_axi_rdata <= {24'h0, config_byte_high3_r};
					`PMRC_OFF_MODE: s_axi_rdata <= {29'h0, mode_r};
					`PMRC_OFF_IRQ_STAT: s_axi_rdata <= {24'h0, irq_stat_r};
					`PMRC_OFF_IRQ_EN: s_axi_rdata <= {24'h0, irq_en_r};
					`PMRC_OFF_IRQ_CLR, `PMRC_OFF_CTRL: s_axi_rdata <= 32'h0;
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	//======================================================================
	// Software registers, cause flags and interrupt
	// Events: 0 sleep entry, 1 wake, 2 pin reset, 3 watchdog, 4 brown-out, 5 instr reset, 6 stack
	wire [7:0] evt = {1'b0, (kind == `PMRC_K_STK_FULL) || (kind == `PMRC_K_STK_UNDER), kind == `PMRC_K_INSTR,
		kind == `PMRC_K_BOR, wdt_edge, (kind == `PMRC_K_PIN_RUN) || (kind == `PMRC_K_PIN_SLEEP),
		(irq_wake || wdt_wake) && in_low_power, sleep_instr && (mode_r == tgt_r)};
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clock_select_reg_r <= `PMRC_CLKSEL_RST;
			config_byte_high3_r <= `PMRC_CFG_RST;
			reset_cause_reg_r <= `PMRC_CAUSE_RST;
			irq_stat_r <= 8'h00;
			irq_en_r <= 8'h00;
			swrst_r <= 1'b0;
			sys_reset_req <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			swrst_r <= wr_ctl && wdata_r[`PMRC_CTRL_SWRST_BIT];
			sys_reset_req <= any_reset;
			irq <= |(irq_stat_r & irq_en_r);
			irq_stat_r <= (irq_stat_r & ~(wr_clr ? wdata_r[7:0] : 8'h00)) | evt; // Set wins
			if (wr_en)
				irq_en_r <= wdata_r[7:0];
			if (wr_cfg)
				config_byte_high3_r <= wdata_r[7:0];
			if (por_act || bor_act)
				clock_select_reg_r <= `PMRC_CLKSEL_RST; // Others keep contents
			else if (wr_clk)
				clock_select_reg_r <= wdata_r[7:0];
			if (por_act)
				reset_cause_reg_r <= `PMRC_CAUSE_RST;
			else if (kind == `PMRC_K_BOR)
				reset_cause_reg_r <= {reset_cause_reg_r[4:1], 1'b0};
			else if (kind == `PMRC_K_INSTR)
				reset_cause_reg_r <= {1'b0, reset_cause_reg_r[3:0]};
			else if (kind == `PMRC_K_WDT)
				reset_cause_reg_r <= {reset_cause_reg_r[4], 2'h1, reset_cause_reg_r[1:0]};
			else if (wdt_wake && wdt_edge)
				reset_cause_reg_r <= {reset_cause_reg_r[4], 2'h0, reset_cause_reg_r[1:0]};
			else if (sleep_instr && (mode_r == tgt_r) && req_mode == `PMRC_M_SLEEP)
				reset_cause_reg_r <= {reset_cause_reg_r[4:3], 1'b0, reset_cause_reg_r[1:0]};
			else if (wr_ctl && wdata_r[`PMRC_CTRL_REARM_BIT])
				reset_cause_reg_r <= 5'h1f; // Software rearms flags
		end
	end
endmodule // pmrc_top

// ===== verif/pmrc_monitor.sv
// Port-level checks of the power mode and reset control block
`timescale 1ns/1ps
//==========================================
// Checker
module pmrc_monitor (
	input wire core_clk,
	input wire rst_n,
	input wire external_reset_pin_n,
	input wire sleep_instr,
	input wire reset_instr,
	input wire stack_full,
	input wire stack_under,
	input wire irq_wake,
	input wire watchdog_timeout,
	input wire cpu_clk_en,
	input wire periph_clk_en,
	input wire pri_osc_sel,
	input wire sec_osc_sel,
	input wire int_fast_sel,
	input wire int_post_sel,
	input wire int_slow_sel,
	input wire sys_reset_req
);
	wire [4:0] src_w = {pri_osc_sel, sec_osc_sel, int_fast_sel, int_post_sel, int_slow_sel};
	wire full_run_w = pri_osc_sel && cpu_clk_en && periph_clk_en;
	default clocking mon_cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_sleep_cut: assert property (sleep_instr |-> ##2 !cpu_clk_en)
		else $error("cpu clock on after sleep");
	a_src_onehot: assert property ($onehot0(src_w))
		else $error("two sources selected");
	a_clk_has_src: assert property (periph_clk_en |-> $onehot(src_w))
		else $error("clock enabled without one source");
	a_cpu_needs_per: assert property (cpu_clk_en |-> periph_clk_en)
		else $error("cpu clocked without peripherals");
	a_wake_primary: assert property (irq_wake |-> ##[1:8] full_run_w)
		else $error("no primary run after wake");
	a_wdt_primary: assert property ($rose(watchdog_timeout) |-> ##[1:12] full_run_w)
		else $error("no primary run after watchdog");
	a_instr_req: assert property (reset_instr |=> sys_reset_req)
		else $error("no request after reset instruction");
	a_stack_req: assert property ((stack_full || stack_under) |=> sys_reset_req)
		else $error("no request after stack fault");
	a_short_glitch: assert property (($rose(external_reset_pin_n) && $past(external_reset_pin_n, 11)) |-> !sys_reset_req [*8])
		else $error("short pin pulse caused reset");
	a_reset_primary: assert property ($rose(rst_n) |-> full_run_w)
		else $error("not in primary run after reset");
endmodule // pmrc_monitor

// ===== verif/pmrc_cpu_model.sv
// Behavioural model of the CPU core events, power-on and the external reset pin
`timescale 1ns/1ps
//==========================================
// Partner model
module pmrc_cpu_model (
	input wire core_clk,
	output logic por_n,
	output logic external_reset_pin_n,
	output wire sleep_instr,
	output wire irq_wake,
	output wire reset_instr,
	output wire stack_full,
	output wire stack_under,
	output wire brownout_evt,
	output wire watchdog_timeout
);
	logic [6:0] ev;
	assign {watchdog_timeout, brownout_evt, stack_under, stack_full, reset_instr, irq_wake, sleep_instr} = ev;
	initial
	begin
		ev = 7'h00;
		external_reset_pin_n = 1'b1;
		por_n = 1'b0;
		repeat (12) @(posedge core_clk);
		por_n <= 1'b1;
	end
	// Event strobes: one cycle for core events and the watchdog reset, four for brown-out and the watchdog wake
	task pulse(input int k, input int len);
		@(posedge core_clk);
		ev[k] <= 1'b1;
		repeat (len) @(posedge core_clk);
		ev[k] <= 1'b0;
	endtask
	// Pin idles high on its pull-up; only this press ever pulls it
	task pin_low(input int len);
		@(posedge core_clk);
		external_reset_pin_n <= 1'b0;
		repeat (len) @(posedge core_clk);
		external_reset_pin_n <= 1'b1;
	endtask
endmodule // pmrc_cpu_model

// ===== verif/pmrc_top_tb.sv
// Self-checking testbench of the power mode and reset control block
`timescale 1ns/1ps
//==========================================
// Testbench
module pmrc_top_tb;
	logic core_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, sys_reset_req;
	logic cpu_clk_en, periph_clk_en, pri_osc_sel, sec_osc_sel, int_fast_sel, int_post_sel, int_slow_sel;
	wire por_n, external_reset_pin_n, sleep_instr, irq_wake, reset_instr, stack_full, stack_under;
	wire brownout_evt, watchdog_timeout;
	int mismatches = 0, check_count = 0, seed = 32'heea9, rq_cnt = 0, n, i;
	logic [33:0] exp_q[$], msk_q[$], e_t, m_t;
	logic g, sl;
	logic [1:0] s, sub;
	logic [6:0] e;
	pmrc_top dut (.*);
	pmrc_cpu_model p (.*);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task print_verdict;
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task cmp(input string nm, input logic [33:0] ex, input logic [33:0] got);
		check_count++;
		if (got !== ex)
		begin
			mismatches++;
			$display("mismatch %s exp %h got %h", nm, ex, got);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		int k;
		exp_q.push_back((a == 12'h000 || a == 12'h008 || a == 12'h014 || a == 12'h018 || a == 12'h01c)
			? 34'h0 : 34'h2);
		msk_q.push_back(34'h3);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 60; k++)
		begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (k == 60) cmp("write timeout", 0, 1);
	endtask
	task rd(input logic [11:0] a, input logic [33:0] ex, input logic [33:0] m);
		int k;
		exp_q.push_back(ex & m);
		msk_q.push_back(m);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 60; k++)
		begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (k == 60) cmp("read timeout", 0, 1);
	endtask
	task ck(input logic [6:0] ex, input logic [6:0] m);
		cmp("clocks", {27'h0, ex & m}, {27'h0, m & {cpu_clk_en, periph_clk_en, pri_osc_sel, sec_osc_sel,
			int_fast_sel, int_post_sel, int_slow_sel}});
	endtask
	task go(input int k, input int len);
		p.pulse(k, len);
		repeat (8) @(posedge core_clk);
	endtask
	// Read and write responses are matched against the oldest note as they appear
	always @(posedge core_clk)
	begin
		if (sys_reset_req) rq_cnt <= rq_cnt + 1;
		if (((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) && exp_q.size() > 0)
		begin
			e_t = exp_q.pop_front();
			m_t = msk_q.pop_front();
			cmp("response", e_t, (s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {32'h0, s_axi_bresp}) & m_t);
		end
	end
	initial
	begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(12'h000, 34'h0, 34'hff);
		rd(12'h008, 34'h80, 34'hff);
		rd(12'h004, 34'h1c, 34'h1f);
		rd(12'h020, {2'h2, 32'h0}, {34{1'b1}});
		wr(12'h024, 32'h0);
		wr(12'h000, {24'($random(seed)), 8'h81});
		repeat (8) @(posedge core_clk);
		ck(7'h70, 7'h7f);
		rd(12'h000, 34'h81, {34{1'b1}});
		for (i = 0; i < 8; i++)
		begin
			g = i[2];
			s = i[1:0];
			sub = {g & ~s[0], s[0]};
			sl = !g && s == 2'h0;
			wr(12'h008, {24'h0, 2'h2, sub, 4'h0});
			wr(12'h000, {24'h0, g, 5'h0, s});
			go(0, 1);
			e = {!g && !sl, !sl, s == 2'h0, s == 2'h1, s[1] && sub == 2'h0, s[1] && sub == 2'h1, s[1] && sub == 2'h2};
			ck(e, sl ? 7'h60 : 7'h7f);
			rd(12'h00c, sl ? 34'h6 : 34'(g * 3 + (s[1] ? 2 : s)), 34'h7);
			go(1, 1);
			ck(7'h70, 7'h7f);
		end
		wr(12'h000, 32'h01);
		go(0, 1);
		wr(12'h000, 32'h81);
		go(0, 1);
		ck(7'h28, 7'h7f);
		go(1, 1);
		wr(12'h014, 32'h0);
		rd(12'h010, 34'h3, 34'h3);
		cmp("irq", 34'h0, {33'h0, irq});
		wr(12'h014, 32'h3);
		repeat (3) @(posedge core_clk);
		cmp("irq", 34'h1, {33'h0, irq});
		wr(12'h018, 32'h7f);
		repeat (3) @(posedge core_clk);
		cmp("irq", 34'h0, {33'h0, irq});
		n = rq_cnt;
		p.pin_low(2 + ($unsigned($random(seed)) % 9));
		repeat (30) @(posedge core_clk);
		cmp("reset request", 34'h0, 34'(rq_cnt - n));
		wr(12'h008, 32'h0);
		p.pin_low(40);
		repeat (30) @(posedge core_clk);
		cmp("reset request", 34'h0, 34'(rq_cnt - n));
		wr(12'h008, 32'h80);
		wr(12'h000, 32'h0);
		go(0, 1);
		p.pin_low(40);
		repeat (30) @(posedge core_clk);
		cmp("reset request", 34'h1, 34'(rq_cnt != n));
		ck(7'h70, 7'h7f);
		go(2, 1);
		rd(12'h004, 34'h0, 34'h10);
		for (i = 3; i < 6; i++)
		begin
			n = rq_cnt;
			go(i, i == 5 ? 4 : 1);
			cmp("reset request", 34'h1, 34'(rq_cnt > n));
		end
		wr(12'h000, 32'h80);
		go(0, 1);
		go(6, 4);
		repeat (4) @(posedge core_clk);
		ck(7'h70, 7'h7f);
		rd(12'h000, 34'h80, {34{1'b1}});
		n = rq_cnt;
		wr(12'h01c, 32'h3);
		go(6, 1);
		cmp("reset request", 34'h2, 34'(rq_cnt - n));
		rd(12'h004, 34'h07, 34'h1f);
		go(0, 1);
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		ck(7'h70, 7'h7f);
		repeat (5) @(posedge core_clk);
		cmp("reads left", 34'h0, 34'(exp_q.size()));
		print_verdict();
	end
endmodule // pmrc_top_tb
bind pmrc_top pmrc_monitor u_mon (.*);
